// ### core/dma_track_pkg.sv
// Package of register offsets, field layouts and carrier types for the size and pointer tracker
package dma_track_pkg;
   localparam int          ADDR_W          = 8;
   localparam int          DATA_W          = 32;
   localparam int          FIELD_W         = 16;
   localparam int          FULL_W          = 17;
   // Register offsets, byte addresses
   localparam logic [7:0]  OFS_SRC_SIZE    = 8'h00;
   localparam logic [7:0]  OFS_DEST_SIZE   = 8'h04;
   localparam logic [7:0]  OFS_SRC_PTR     = 8'h08;
   localparam logic [7:0]  OFS_DEST_PTR    = 8'h0c;
   localparam logic [7:0]  OFS_CELL_SIZE   = 8'h10;
   localparam logic [7:0]  OFS_CTRL        = 8'h14;
   localparam logic [7:0]  OFS_IRQ_STAT    = 8'h18;
   localparam logic [7:0]  OFS_IRQ_CLR     = 8'h1c;
   localparam logic [7:0]  OFS_IRQ_EN      = 8'h20;
   // Reset values
   localparam logic [15:0] RST_FIELD       = 16'h0000;
   localparam logic [2:0]  RST_FLAGS       = 3'h0;
   localparam logic [31:0] RD_UNMAPPED     = 32'h0000_0000;
   // Field positions
   localparam int          CTRL_PAT_BIT    = 0;
   localparam int          FLAG_CELL_BIT   = 0;
   localparam int          FLAG_HALF_BIT   = 1;
   localparam int          FLAG_DONE_BIT   = 2;
   localparam int          NUM_FLAGS       = 3;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic              wr;
      logic              rd;
   } reg_req_t;

   typedef struct packed {
      logic       valid;       // One bus transfer moved bytes
      logic [2:0] nbytes;      // Bytes in that transfer, 1 to 4
      logic       pat_match;   // Pattern matched in this transfer
   } xfer_t;
endpackage : dma_track_pkg

// ### core/dma_size_decode.sv
// Expands a 16-bit size field to its 17-bit byte count, zero meaning 65,536
`timescale 1ns/1ps
module dma_size_decode (
   input  wire logic [15:0] field,
   output logic      [16:0] bytes
);
   import dma_track_pkg::*;

   // Zero field stands for the full 2^16 byte count
   always_comb begin
      if (field == RST_FIELD) begin
         bytes = 17'h10000;
      end else begin
         bytes = {1'b0, field};
      end
   end
endmodule : dma_size_decode

// ### core/dma_size_ptr_track.sv
// Size settings, progress pointers and flag logic of one DMA channel
//
// Operation
// R1 - Destination size is a byte count; zero means 65,536 bytes.
// R2 - Cell size is bytes per trigger event; zero means 65,536 bytes.
// R3 - Bits 31 to 16 of size and pointer registers read as zero.
// R4 - Read-only source pointer holds index of current source byte, 0 to 65,535.
// R5 - Read-only destination pointer holds index of current destination byte.
// R6 - In pattern-detect mode a pattern match clears the source pointer.
// R7 - Reset clears destination size, cell size and both pointers.
// R8 - Source size is a byte count; zero means 65,536 bytes.
// R9 - Done flag when pointer equals destination size; half flag at half.
// R10 - Cell flag each time cell-size bytes have been moved.
// R11 - Pointers advance by bytes per transfer and clear at block end.
`timescale 1ns/1ps
module dma_size_ptr_track (
   input  wire logic                        sys_clk,
   input  wire logic                        rst,
   input  wire dma_track_pkg::reg_req_t     req,
   input  wire dma_track_pkg::xfer_t        xfer,
   output logic      [31:0]                 rdata,
   output logic                             irq,
   output logic                             block_done,
   output logic                             cell_done
);
   import dma_track_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   typedef struct packed {
      logic [15:0]          src_size;
      logic [15:0]          dest_size;
      logic [15:0]          cell_size;
      logic [15:0]          src_ptr;
      logic [15:0]          dest_ptr;
      logic [16:0]          cell_cnt;
      logic                 pat_mode;
      logic [NUM_FLAGS-1:0] stat;
      logic [NUM_FLAGS-1:0] en;
      logic [31:0]          rdata;
      logic                 irq;
      logic                 block_done;
      logic                 cell_done;
   } state_t;

   state_t st_ff;
   state_t nxt_st;

   logic [16:0] src_bytes;
   logic [16:0] dest_bytes;
   logic [16:0] cell_bytes;

   ////////////////////////////////////////////////////////////////////////////
   // Size fields expanded to byte counts
   // R8 source size decode
   dma_size_decode u_src_dec (
      .field (st_ff.src_size),
      .bytes (src_bytes)
   );

   // R1 destination size decode
   dma_size_decode u_dest_dec (
      .field (st_ff.dest_size),
      .bytes (dest_bytes)
   );

   // R2 cell size decode
   dma_size_decode u_cell_dec (
      .field (st_ff.cell_size),
      .bytes (cell_bytes)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Next state
   always_comb begin
      logic [16:0]          src_next;
      logic [16:0]          dest_next;
      logic [16:0]          cell_next;
      logic                 src_end;
      logic                 dest_end;
      logic                 blk_end;
      logic                 pat_clr;
      logic                 half_hit;
      logic [NUM_FLAGS-1:0] events;
      logic [NUM_FLAGS-1:0] clr_mask;
      src_next  = 17'h00000;
      dest_next = 17'h00000;
      cell_next = 17'h00000;
      src_end   = 1'b0;
      dest_end  = 1'b0;
      blk_end   = 1'b0;
      pat_clr   = 1'b0;
      half_hit  = 1'b0;
      events    = RST_FLAGS;
      clr_mask  = RST_FLAGS;
      nxt_st    = st_ff;
      nxt_st.block_done = 1'b0;
      nxt_st.cell_done  = 1'b0;

      // Register writes; pointers are read only
      if (req.wr) begin
         case (req.addr)
            OFS_SRC_SIZE:  nxt_st.src_size  = req.wdata[15:0];
            OFS_DEST_SIZE: nxt_st.dest_size = req.wdata[15:0];
            OFS_CELL_SIZE: nxt_st.cell_size = req.wdata[15:0];
            OFS_CTRL:      nxt_st.pat_mode  = req.wdata[CTRL_PAT_BIT];
            OFS_IRQ_CLR:   clr_mask         = req.wdata[NUM_FLAGS-1:0];
            OFS_IRQ_EN:    nxt_st.en        = req.wdata[NUM_FLAGS-1:0];
            default:       nxt_st.en        = st_ff.en;
         endcase
      end

      // Progress tracking on each bus transfer
      if (xfer.valid) begin
         // R11 pointers advance
         src_next  = {1'b0, st_ff.src_ptr} + {14'h0000, xfer.nbytes};
         dest_next = {1'b0, st_ff.dest_ptr} + {14'h0000, xfer.nbytes};
         cell_next = st_ff.cell_cnt + {14'h0000, xfer.nbytes};
         src_end   = src_next >= src_bytes;
         dest_end  = dest_next >= dest_bytes;
         // Block ends when the larger of the two sizes is covered
         blk_end   = (src_bytes >= dest_bytes) ? src_end : dest_end;
         // R6 pattern clear
         pat_clr   = st_ff.pat_mode && xfer.pat_match;
         // R9 half and done compare; byte counts may skip odd midpoints
         half_hit  = ({1'b0, st_ff.dest_ptr} < (dest_bytes >> 1)) &&
                     (dest_next >= (dest_bytes >> 1));
         events[FLAG_HALF_BIT] = half_hit;
         events[FLAG_DONE_BIT] = dest_end;
         // R10 cell completion
         if (cell_next >= cell_bytes) begin
            events[FLAG_CELL_BIT] = 1'b1;
            nxt_st.cell_cnt       = 17'h00000;
            nxt_st.cell_done      = 1'b1;
         end else begin
            nxt_st.cell_cnt = cell_next;
         end
         // R4 source index, wraps with the source
         nxt_st.src_ptr  = src_end ? RST_FIELD : src_next[15:0];
         // R5 destination index
         nxt_st.dest_ptr = dest_end ? RST_FIELD : dest_next[15:0];
         // R11 clear at block end
         if (blk_end || pat_clr) begin
            nxt_st.src_ptr    = RST_FIELD;
            nxt_st.dest_ptr   = RST_FIELD;
            nxt_st.cell_cnt   = 17'h00000;
            nxt_st.block_done = 1'b1;
         end
      end

      // Sticky flags: an event beats a same-cycle clear
      nxt_st.stat = (st_ff.stat & ~clr_mask) | events;
      nxt_st.irq  = |(nxt_st.stat & nxt_st.en);

      // Read data, valid the cycle after the strobe
      nxt_st.rdata = RD_UNMAPPED;
      if (req.rd) begin
         // R3 upper bits zero
         case (req.addr)
            OFS_SRC_SIZE:  nxt_st.rdata = {16'h0000, st_ff.src_size};
            OFS_DEST_SIZE: nxt_st.rdata = {16'h0000, st_ff.dest_size};
            OFS_SRC_PTR:   nxt_st.rdata = {16'h0000, st_ff.src_ptr};
            OFS_DEST_PTR:  nxt_st.rdata = {16'h0000, st_ff.dest_ptr};
            OFS_CELL_SIZE: nxt_st.rdata = {16'h0000, st_ff.cell_size};
            OFS_CTRL:      nxt_st.rdata = {31'h00000000, st_ff.pat_mode};
            OFS_IRQ_STAT:  nxt_st.rdata = {29'h00000000, st_ff.stat};
            OFS_IRQ_EN:    nxt_st.rdata = {29'h00000000, st_ff.en};
            default:       nxt_st.rdata = RD_UNMAPPED;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // State register
   // R7 reset clears sizes and pointers
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign rdata      = st_ff.rdata;
   assign irq        = st_ff.irq;
   assign block_done = st_ff.block_done;
   assign cell_done  = st_ff.cell_done;
endmodule : dma_size_ptr_track

// ### verification/dma_bus_mem_model.sv
// Bus-side model that reports byte transfers to the tracker
`timescale 1ns/1ps
module dma_bus_mem_model (
   input  wire logic                 sys_clk,
   output      dma_track_pkg::xfer_t xfer
);
   import dma_track_pkg::*;
   // Idle lines carry junk on purpose: only valid may qualify them
   initial xfer = '{1'b0, 3'h7, 1'b1};
   // n transfers of nb bytes, gap idle cycles apart; pat marks the last
   task automatic burst(input int n, input logic [2:0] nb, input int gap, input logic pat);
      for (int i = 0; i < n; i++) begin
         @(posedge sys_clk);
         xfer <= '{1'b1, nb, pat && (i == n - 1)};
         repeat (gap) begin
            @(posedge sys_clk);
            xfer <= '{1'b0, ~nb, 1'b1};
         end
      end
      @(posedge sys_clk);
      xfer <= '{1'b0, ~nb, 1'b1};
   endtask : burst
endmodule : dma_bus_mem_model

// ### verification/dma_track_asserts.sv
// Assertions on the tracker's register and event ports
`timescale 1ns/1ps
module dma_track_asserts (
   input wire logic                    sys_clk,
   input wire logic                    rst,
   input wire dma_track_pkg::reg_req_t req,
   input wire dma_track_pkg::xfer_t    xfer,
   input wire logic [31:0]             rdata,
   input wire logic                    irq,
   input wire logic                    block_done,
   input wire logic                    cell_done
);
   import dma_track_pkg::*;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);
   upper_zero_a: assert property (rdata[31:16] == 16'h0)
      else $error("upper read bits set");
   unmapped_zero_a: assert property ($past(req.rd) && $past(req.addr) > OFS_IRQ_EN
      |-> rdata == 32'h0) else $error("unmapped read not zero");
   stat_width_a: assert property ($past(req.rd) && $past(req.addr) == OFS_IRQ_STAT
      |-> rdata[31:3] == 29'h0) else $error("status spare bits set");
   reset_quiet_a: assert property ($fell(rst) |-> !irq && !block_done && rdata == 32'h0)
      else $error("outputs busy after reset");
   block_cause_a: assert property (block_done |-> $past(xfer.valid))
      else $error("block end without transfer");
   cell_cause_a: assert property (cell_done |-> $past(xfer.valid))
      else $error("cell end without transfer");
   irq_rise_a: assert property ($rose(irq) |-> $past(xfer.valid) || $past(req.wr)
      || $past(req.wr, 2)) else $error("irq rose without cause");
   irq_fall_a: assert property ($fell(irq) |-> $past(req.wr) || $past(req.wr, 2))
      else $error("irq fell without write");
   cover property (block_done);
   cover property (cell_done);
   cover property (irq);
endmodule : dma_track_asserts
bind dma_size_ptr_track dma_track_asserts u_chk (.sys_clk(sys_clk), .rst(rst), .req(req),
   .xfer(xfer), .rdata(rdata), .irq(irq), .block_done(block_done), .cell_done(cell_done));

// ### verification/dma_size_ptr_track_tb.sv
// Self-checking bench for the size and pointer tracker
`timescale 1ns/1ps
module dma_size_ptr_track_tb;
   import dma_track_pkg::*;
   logic        sys_clk = 1'b0;
   logic        rst = 1'b1;
   reg_req_t    req = '0;
   xfer_t       xfer;
   logic [31:0] rdata;
   logic        irq;
   logic        block_done;
   logic        cell_done;
   int          block_pulses = 0;
   int          cell_pulses = 0;
   int          mismatches = 0;
   int          check_count = 0;
   logic [7:0]  rst_ofs [5] = '{OFS_DEST_SIZE, OFS_SRC_PTR, OFS_DEST_PTR, OFS_CELL_SIZE, 8'h24};

   always #5 sys_clk = ~sys_clk;

   dma_size_ptr_track uut (.sys_clk(sys_clk), .rst(rst), .req(req), .xfer(xfer),
      .rdata(rdata), .irq(irq), .block_done(block_done), .cell_done(cell_done));
   dma_bus_mem_model mem (.sys_clk(sys_clk), .xfer(xfer));

   // Count completion pulses; each stands one cycle, so one sample per edge
   always @(posedge sys_clk) begin
      if (block_done === 1'b1) block_pulses <= block_pulses + 1;
      if (cell_done === 1'b1) cell_pulses <= cell_pulses + 1;
   end

   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : tally_and_finish

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         mismatches++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      req <= '{a, d, 1'b1, 1'b0};
      @(posedge sys_clk);
      req.wr <= 1'b0;
   endtask : wr_reg

   // Read data stand only in the cycle after the strobe
   task automatic rd_reg(input logic [7:0] a, input logic [31:0] exp);
      @(posedge sys_clk);
      req <= '{a, 32'h0, 1'b0, 1'b1};
      @(posedge sys_clk);
      req.rd <= 1'b0;
      #1 chk(rdata, exp);
   endtask : rd_reg

   // Hang guard
   initial begin
      repeat (100000) @(posedge sys_clk);
      mismatches++;
      tally_and_finish();
   end

   initial begin
      repeat (12) @(posedge sys_clk);
      rst <= 1'b0;
      foreach (rst_ofs[i]) rd_reg(rst_ofs[i], 32'h0);
      wr_reg(OFS_DEST_SIZE, 32'hffff_0008);
      rd_reg(OFS_DEST_SIZE, 32'h8);
      wr_reg(OFS_SRC_SIZE, 32'h8);
      wr_reg(OFS_CELL_SIZE, 32'h4);
      wr_reg(OFS_IRQ_EN, 32'h7);
      mem.burst(3, 3'h2, 0, 1'b0);
      rd_reg(OFS_SRC_PTR, 32'h6);
      rd_reg(OFS_DEST_PTR, 32'h6);
      rd_reg(OFS_IRQ_STAT, 32'h3);
      mem.burst(1, 3'h2, 1, 1'b0);
      rd_reg(OFS_DEST_PTR, 32'h0);
      rd_reg(OFS_IRQ_STAT, 32'h7);
      wr_reg(OFS_IRQ_CLR, 32'h7);
      wr_reg(OFS_IRQ_EN, 32'h0);
      mem.burst(2, 3'h2, 2, 1'b0);
      rd_reg(OFS_IRQ_STAT, 32'h3);
      chk(32'(irq), 32'h0);
      wr_reg(OFS_IRQ_EN, 32'h7);
      wr_reg(OFS_SRC_PTR, 32'h1234);
      rd_reg(OFS_SRC_PTR, 32'h4);
      chk(32'(irq), 32'h1);
      // A match outside pattern-detect mode must not clear the pointer
      mem.burst(1, 3'h1, 0, 1'b1);
      rd_reg(OFS_SRC_PTR, 32'h5);
      wr_reg(OFS_CTRL, 32'h1);
      mem.burst(1, 3'h1, 0, 1'b1);
      rd_reg(OFS_SRC_PTR, 32'h0);
      wr_reg(OFS_IRQ_CLR, 32'h7);
      wr_reg(OFS_DEST_SIZE, 32'h0);
      wr_reg(OFS_SRC_SIZE, 32'h0);
      wr_reg(OFS_CELL_SIZE, 32'h0);
      mem.burst(16383, 3'h4, 0, 1'b0);
      rd_reg(OFS_DEST_PTR, 32'hfffc);
      rd_reg(OFS_IRQ_STAT, 32'h2);
      mem.burst(1, 3'h4, 0, 1'b0);
      rd_reg(OFS_IRQ_STAT, 32'h7);
      // Destination shorter than source: only the destination pointer wraps
      wr_reg(OFS_DEST_SIZE, 32'h4);
      wr_reg(OFS_SRC_SIZE, 32'h8);
      mem.burst(1, 3'h4, 0, 1'b0);
      rd_reg(OFS_DEST_PTR, 32'h0);
      rd_reg(OFS_SRC_PTR, 32'h4);
      chk(32'(block_pulses), 32'h3);
      chk(32'(cell_pulses), 32'h4);
      tally_and_finish();
   end
endmodule : dma_size_ptr_track_tb
